//--- scrx_regs.vh
// Register map, field positions and reset values of the receive clock block
`ifndef SCRX_REGS_VH
`define SCRX_REGS_VH

// ==========================================================
// Register byte offsets
`define SCRX_RX_CLK_MODE_OFS  12'h010
`define SCRX_IRQ_ENABLE_OFS   12'h044
`define SCRX_IRQ_DISABLE_OFS  12'h048
`define SCRX_IRQ_MASK_OFS     12'h04c
`define SCRX_STATUS_OFS       12'h040

// ==========================================================
// Receive clock mode fields
`define SCRX_SRC_SEL_LSB      0
`define SCRX_SRC_SEL_MSB      1
`define SCRX_OUT_MODE_LSB     2
`define SCRX_OUT_MODE_MSB     4
`define SCRX_INV_BIT          5
`define SCRX_RX_CLK_MODE_RST  6'h00

// Clock source codes
`define SCRX_SRC_DIV          2'h0
`define SCRX_SRC_TX           2'h1
`define SCRX_SRC_PAD          2'h2

// Output mode codes
`define SCRX_OUT_NONE         3'h0
`define SCRX_OUT_CONT         3'h1
`define SCRX_OUT_XFER         3'h2

// ==========================================================
// Interrupt bit positions
`define SCRX_IRQ_TX_READY     0
`define SCRX_IRQ_TX_DRAINED   1
`define SCRX_IRQ_RX_READY     4
`define SCRX_IRQ_RX_OVERRUN   5
`define SCRX_IRQ_COMPARE_A    8
`define SCRX_IRQ_COMPARE_B    9
`define SCRX_IRQ_TX_SYNC      10
`define SCRX_IRQ_RX_SYNC      11
`define SCRX_IRQ_USED         12'hf33
`define SCRX_IRQ_MASK_RST     12'h000

`endif

//--- scrx_pad_sync.v
// Three-stage synchroniser for the receive clock pad input
`timescale 1ns/1ps
module scrx_pad_sync
(
  input  wire ref_clk_i,  // System clock
  input  wire resetn_i,   // Synchronous reset, active low
  input  wire pad_i,      // Asynchronous pad level
  output reg  level_o     // Filtered level
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // ==========================================================
  // Stages; a change counts once stage two and three agree
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      s1_q <= pad_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_o <= s3_q;
    end
  end

endmodule // scrx_pad_sync

//--- scrx_top.v
// Receive clock management and interrupt mask of the sync serial controller
//
// What this block does
// RULE1: Receive clock from tx, divider or pad
// RULE2: Selected receive clock can be inverted
// RULE3: Pad driven continuously or only during transfer
// RULE4: Inversion never affects the pad output
// RULE5: Software must not combine pad source, continuous
// RULE6: Mask bit 11 shows rx sync enable
// RULE7: Mask bit 10 shows tx sync enable
// RULE8: Mask bit 9 shows compare B enable
// RULE9: Mask bit 8 shows compare A enable
// RULE10: Irq when flagged and enabled; set/clear writes
`timescale 1ns/1ps
`include "scrx_regs.vh"
module scrx_top
(
  input  wire        ref_clk_i,      // 50 MHz system clock
  input  wire        resetn_i,       // Synchronous reset, active low
  input  wire        psel,           // APB select
  input  wire        penable,        // APB enable
  input  wire        pwrite,         // APB direction
  input  wire [11:0] paddr,          // APB byte address
  input  wire [31:0] pwdata,         // APB write data
  output reg  [31:0] prdata,         // APB read data
  output reg         pready,         // APB ready
  output reg         pslverr,        // APB error for unmapped address
  input  wire        tx_clk_i,       // Transmit clock level, same domain
  input  wire        div_clk_i,      // Divider clock level, same domain
  input  wire        xfer_active_i,  // Receive transfer in progress
  input  wire [11:0] event_i,        // One-cycle event pulses per source
  input  wire        rx_clk_pad_i,   // Receive clock pad input
  output reg         rx_clk_pad_o,   // Receive clock pad output
  output reg         rx_clk_pad_oe_o,// Pad output enable, high drives
  output reg         rx_clk_o,       // Internal receive clock
  output reg         irq_o           // Level interrupt
);

  // ==========================================================
  // Registers and decode
  reg  [5:0]  rx_clk_mode_q;
  reg  [11:0] irq_mask_q;
  reg  [11:0] status_q;
  wire        pad_level;
  wire        acc;
  wire        wr;
  wire        rd_status;
  reg         raw_clk;
  reg  [31:0] rdata_d;
  wire [1:0]  src_sel;
  wire [2:0]  out_mode;
  wire [11:0] used;
  wire [11:0] clr_bits;

  // Address decode for the error answer only; the read mux decodes paddr in its own case
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `SCRX_RX_CLK_MODE_OFS) || (a == `SCRX_IRQ_ENABLE_OFS) ||
                  (a == `SCRX_IRQ_DISABLE_OFS) || (a == `SCRX_IRQ_MASK_OFS) ||
                  (a == `SCRX_STATUS_OFS);
    end
  endfunction

  assign acc       = psel & penable & ~pready;
  assign wr        = acc & pwrite;
  assign rd_status = acc & ~pwrite & (paddr == `SCRX_STATUS_OFS);
  assign src_sel   = rx_clk_mode_q[`SCRX_SRC_SEL_MSB:`SCRX_SRC_SEL_LSB];
  assign out_mode  = rx_clk_mode_q[`SCRX_OUT_MODE_MSB:`SCRX_OUT_MODE_LSB];
  assign used      = `SCRX_IRQ_USED;
  // Status clears on read of the status register
  assign clr_bits  = rd_status ? 12'hfff : 12'h000;

  scrx_pad_sync u_pad_sync
  (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .pad_i     (rx_clk_pad_i),
    .level_o   (pad_level)
  );

  // ==========================================================
  // Clock source selection
  always @*
  begin
    case (src_sel)
      `SCRX_SRC_DIV: raw_clk = div_clk_i;                        // RULE1
      `SCRX_SRC_TX:  raw_clk = tx_clk_i;                         // RULE1
      `SCRX_SRC_PAD: raw_clk = pad_level;                        // RULE1
      default:       raw_clk = div_clk_i;
    endcase
  end

  // ==========================================================
  // Clock outputs; pad output uses the uninverted clock
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      rx_clk_o        <= 1'b0;
      rx_clk_pad_o    <= 1'b0;
      rx_clk_pad_oe_o <= 1'b0;
    end
    else
    begin
      rx_clk_o     <= raw_clk ^ rx_clk_mode_q[`SCRX_INV_BIT];    // RULE2
      rx_clk_pad_o <= raw_clk;                                   // RULE4
      // Pad source with continuous drive would loop the pad onto itself
      rx_clk_pad_oe_o <= (out_mode == `SCRX_OUT_CONT) ||
                         ((out_mode == `SCRX_OUT_XFER) && xfer_active_i); // RULE3
    end
  end

  // ==========================================================
  // Register writes, mask set/clear and sticky status
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      rx_clk_mode_q <= `SCRX_RX_CLK_MODE_RST;
      irq_mask_q    <= `SCRX_IRQ_MASK_RST;
      status_q      <= 12'h000;
      irq_o         <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `SCRX_RX_CLK_MODE_OFS)
        rx_clk_mode_q <= pwdata[5:0];
      if (wr && paddr == `SCRX_IRQ_ENABLE_OFS)
        irq_mask_q <= irq_mask_q | (pwdata[11:0] & used);        // RULE10
      else if (wr && paddr == `SCRX_IRQ_DISABLE_OFS)
        irq_mask_q <= irq_mask_q & ~pwdata[11:0];                // RULE10
      // Set wins over the read clear in the same cycle
      status_q <= (status_q & ~clr_bits) | (event_i & used);
      irq_o    <= |(status_q & irq_mask_q);                      // RULE10
    end
  end

  // ==========================================================
  // Read mux
  always @*
  begin
    rdata_d = 32'h00000000;
    case (paddr)
      `SCRX_RX_CLK_MODE_OFS: rdata_d[5:0] = rx_clk_mode_q;
      `SCRX_STATUS_OFS:      rdata_d[11:0] = status_q;
      `SCRX_IRQ_MASK_OFS:
      begin
        rdata_d[`SCRX_IRQ_RX_SYNC]   = irq_mask_q[`SCRX_IRQ_RX_SYNC];   // RULE6
        rdata_d[`SCRX_IRQ_TX_SYNC]   = irq_mask_q[`SCRX_IRQ_TX_SYNC];   // RULE7
        rdata_d[`SCRX_IRQ_COMPARE_B] = irq_mask_q[`SCRX_IRQ_COMPARE_B]; // RULE8
        rdata_d[`SCRX_IRQ_COMPARE_A] = irq_mask_q[`SCRX_IRQ_COMPARE_A]; // RULE9
        rdata_d[7:0] = irq_mask_q[7:0];
      end
      default: rdata_d = 32'h00000000;
    endcase
  end

  // ==========================================================
  // APB answer: one wait state, pready for one cycle
  always @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc & ~is_mapped(paddr);
      if (acc && !pwrite)
        prdata <= rdata_d;
    end
  end

endmodule // scrx_top

//--- scrx_sva.sv
// Checker of the receive clock block ports
`timescale 1ns/1ps
module scrx_sva
(
  input wire        ref_clk_i, resetn_i, psel, penable, pwrite, pready, tx_clk_i, div_clk_i,
  input wire        xfer_active_i, rx_clk_pad_o, rx_clk_pad_oe_o, rx_clk_o, irq_o,
  input wire [11:0] paddr, event_i,
  input wire [31:0] pwdata, prdata
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  reg  [1:0]  src_q;
  reg  [2:0]  outm_q;
  reg         inv_q;
  reg  [11:0] msk_q;
  wire        wr = psel & penable & pready & pwrite;
  // Shadows land one edge after the block's, so the clock, pad and irq checks rest while psel is high
  always @(posedge ref_clk_i)
    if (!resetn_i)
      {inv_q, outm_q, src_q, msk_q} <= 18'h0;
    else if (wr && paddr == 12'h010)
      {inv_q, outm_q, src_q} <= pwdata[5:0];
    else if (wr && paddr == 12'h044)
      msk_q <= msk_q | (pwdata[11:0] & 12'hf33);
    else if (wr && paddr == 12'h048)
      msk_q <= msk_q & ~pwdata[11:0];
  a_rx_clk_sel: assert property (!psel && $past(resetn_i) && src_q != 2'h2 |->
    rx_clk_o == ((src_q == 2'h1 ? $past(tx_clk_i) : $past(div_clk_i)) ^ inv_q)) else $error("rx clk");
  a_pad_uninv: assert property (!psel && $past(resetn_i) && src_q != 2'h2 && rx_clk_pad_oe_o |->
    rx_clk_pad_o == (src_q == 2'h1 ? $past(tx_clk_i) : $past(div_clk_i))) else $error("pad out");
  a_pad_drive: assert property (!psel && $past(resetn_i) |-> rx_clk_pad_oe_o ==
    (outm_q == 3'h1 || (outm_q == 3'h2 && $past(xfer_active_i)))) else $error("pad enable");
  a_mask_read: assert property (psel && penable && pready && !pwrite && paddr == 12'h04c |->
    prdata == {20'h0, msk_q}) else $error("mask read");
  a_irq_masked: assert property (!psel && irq_o |-> |msk_q) else $error("irq unmasked");
  a_irq_raise: assert property ((!psel && |(event_i & msk_q)) ##1 !psel |-> ##1 irq_o)
    else $error("irq late");
  a_ready_pulse: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("ready timing");
  a_reset_quiet: assert property (!$past(resetn_i) |-> !irq_o && !rx_clk_pad_oe_o && !pready)
    else $error("reset outputs");
endmodule // scrx_sva
bind scrx_top scrx_sva i_scrx_sva (.*);

//--- scrx_codec.sv
// Model of the external codec that clocks the receive pad
`timescale 1ns/1ps
module scrx_codec
(
  input  wire ref_clk_i, // System clock
  input  wire run_i,     // Frame in progress
  output reg  clk_o      // Pad clock, stands low between frames
);
  reg [1:0] cnt_q = 2'h0;
  initial clk_o = 1'b0;
  always @(posedge ref_clk_i)
  begin
    cnt_q <= run_i ? cnt_q + 2'h1 : 2'h0;
    clk_o <= run_i & cnt_q[1];
  end
endmodule // scrx_codec

//--- scrx_tb.sv
// Self-checking bench of the receive clock block
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  reg         ref_clk_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         tx_clk_i = 1'b0, div_clk_i = 1'b0, xfer_active_i = 1'b0, run = 1'b0, hold = 1'b0;
  reg  [11:0] paddr = 12'h000, event_i = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, pad_i, pad_o, pad_oe, rx_clk_o, irq_o;
  int         err_total = 0, samples_checked = 0, cyc = 0, i;
  always #10 ref_clk_i = ~ref_clk_i;
  scrx_codec i_scrx_codec (.ref_clk_i(ref_clk_i), .run_i(run), .clk_o(pad_i));
  scrx_top i_scrx_top (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clk_i(tx_clk_i), .div_clk_i(div_clk_i), .xfer_active_i(xfer_active_i),
    .event_i(event_i), .rx_clk_pad_i(pad_i), .rx_clk_pad_o(pad_o), .rx_clk_pad_oe_o(pad_oe),
    .rx_clk_o(rx_clk_o), .irq_o(irq_o));
  task final_report;
  begin
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  always @(posedge ref_clk_i)
  begin
    cyc++;
    {tx_clk_i, div_clk_i} <= hold ? 2'b10 : {~tx_clk_i, cyc[1]};
    if (cyc == 3000)
    begin
      err_total++;
      final_report;
    end
  end
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
  begin
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task t_regs;
  begin
    apb(1'b0, 12'h04c, 32'h0);
    `CHK("mask reset", 32'h0, rd)
    apb(1'b1, 12'h044, 32'hffffffff);
    apb(1'b1, 12'h04c, 32'h0);
    apb(1'b0, 12'h04c, 32'h0);
    `CHK("mask all", 32'hf33, rd)
    apb(1'b1, 12'h048, 32'h00000a00);
    apb(1'b0, 12'h04c, 32'h0);
    `CHK("mask part", 32'h533, rd)
    apb(1'b1, 12'h048, 32'hffffffff);
    apb(1'b0, 12'h100, 32'h0);
    `CHK("unmapped", 1'b1, pslverr)
    $display("registers done");
  end
  endtask
  task t_clk;
  begin
    hold <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, 12'h010, {26'h0, i[0], 3'h1, 1'b0, i[1]});
      wt(3);
      `CHK("rx clk", i[1] ^ i[0], rx_clk_o)
      `CHK("pad out", {i[1], 1'b1}, {pad_o, pad_oe})
    end
    hold <= 1'b0;
    apb(1'b1, 12'h010, 32'h0000002a);
    xfer_active_i <= 1'b1;
    run <= 1'b1;
    wt(6);
    `CHK("pad xfer", 1'b1, pad_oe)
    xfer_active_i <= 1'b0;
    run <= 1'b0;
    wt(8);
    `CHK("pad idle", 2'b01, {pad_oe, rx_clk_o})
    $display("clock done");
  end
  endtask
  task pulse(input reg [11:0] b);
  begin
    @(posedge ref_clk_i);
    event_i <= b;
    wt(1);
    event_i <= 12'h000;
    wt(3);
  end
  endtask
  task t_irq;
  begin
    apb(1'b1, 12'h044, 32'h00000100);
    pulse(12'h010);
    `CHK("irq masked", 1'b0, irq_o)
    apb(1'b1, 12'h044, 32'h00000010);
    wt(3);
    `CHK("irq sticky", 1'b1, irq_o)
    apb(1'b1, 12'h048, 32'h00000010);
    wt(3);
    `CHK("irq off", 1'b0, irq_o)
    pulse(12'h100);
    `CHK("irq on", 1'b1, irq_o)
    apb(1'b0, 12'h040, 32'h0);
    `CHK("status", 32'h110, rd)
    wt(3);
    `CHK("irq clear", 1'b0, irq_o)
    $display("interrupt done");
  end
  endtask
  initial
  begin
    wt(6);
    resetn_i <= 1'b1;
    t_regs;
    t_clk;
    t_irq;
    final_report;
  end
endmodule // tb
